/* bench/scpc_card_model.sv */
// Card-side stand-in: access pulses and the idle level
`timescale 1ns/1ns
`default_nettype none

module scpc_card_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic want_idle,
  input  wire logic poke,
  output logic      access,
  output logic      idle
);
  // A card being accessed is never idle in that cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      access <= 1'b0;
      idle   <= 1'b0;
    end else begin
      access <= poke;
      idle   <= want_idle && !poke;
    end
  end
endmodule

`default_nettype wire

/* bench/scpc_checker.sv */
// Port-level assertions for the socket clock power control block
`timescale 1ns/1ns
`default_nettype none

module scpc_checker #(
  parameter int          ADDR_W   = 8,
  parameter int unsigned SLOW_DIV = 16
) (
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PRDATA,
  input wire logic              CARD_ACCESS,
  input wire logic              CARD_CLK_EN,
  input wire logic              CARD_CLK_STOPPED,
  input wire logic              CARD_CLK_SLOWED
);
  logic [4:0] gap;
  logic       gated;
  logic       rd_pm;

  // Counts closed cycles in slow mode only, so a stop spell never pads it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      gap <= 5'h0;
    end else begin
      gap <= (CARD_CLK_SLOWED && !CARD_CLK_EN) ? gap + 5'h1 : 5'h0;
    end
  end

  assign gated = CARD_CLK_STOPPED || CARD_CLK_SLOWED;
  assign rd_pm = PSEL && PENABLE && !PWRITE && PADDR == ADDR_W'(scpc_pkg::SCPC_OFS_PM);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  AST_WAKE_ON_ACCESS: assert property (CARD_ACCESS |=> !gated)
    else $error("card clock gated after access");
  AST_RUN_CLOCKS: assert property (!gated |-> CARD_CLK_EN)
    else $error("clock closed outside idle");
  AST_STOP_HOLDS: assert property (CARD_CLK_STOPPED |-> !CARD_CLK_EN && !CARD_CLK_SLOWED)
    else $error("clock runs while stopped");
  AST_SLOW_BOUND: assert property (CARD_CLK_SLOWED |-> gap < 5'(SLOW_DIV))
    else $error("slow clock missed its pulse");
  AST_SLOW_PERIOD: assert property (CARD_CLK_SLOWED && CARD_CLK_EN && gap != 5'h0
    |-> gap == 5'(SLOW_DIV - 1))
    else $error("slow clock period wrong");
  AST_RSVD_ZERO: assert property (rd_pm |-> (PRDATA & 32'hfcfe_fffe) == 32'h0)
    else $error("reserved bits not zero");
  AST_RATE_STATUS: assert property (rd_pm |-> PRDATA[24] == $past(gated))
    else $error("rate status wrong");
  AST_POLICY_OFF: assert property (rd_pm && !PRDATA[16] |-> !gated)
    else $error("clock gated with policy off");

  COV_STOP: cover property ($rose(CARD_CLK_STOPPED));
  COV_SLOW: cover property ($rose(CARD_CLK_SLOWED));
  COV_WAKE: cover property (CARD_ACCESS ##1 !gated);
endmodule

bind scpc_top scpc_checker #(.ADDR_W(ADDR_W), .SLOW_DIV(SLOW_DIV)) u_chk (
  .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .CARD_ACCESS(CARD_ACCESS), .CARD_CLK_EN(CARD_CLK_EN),
  .CARD_CLK_STOPPED(CARD_CLK_STOPPED), .CARD_CLK_SLOWED(CARD_CLK_SLOWED));

`default_nettype wire

/* bench/test_socket_card_clock_power_control.sv */
// Self-checking bench for the socket clock power control block
`timescale 1ns/1ns
`default_nettype none

module test_socket_card_clock_power_control;
  logic        clk, rstn, psel, penable, pwrite, host, want_idle, poke, perr;
  logic        pready, pslverr, card_access, card_idle, clk_en, stopped, slowed, irq;
  logic [3:0]  pstrb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  int          err_total, checks, n;

  scpc_top dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CARD_ACCESS(card_access), .CARD_IDLE(card_idle),
    .HOST_CLK_SLOWING(host), .CARD_CLK_EN(clk_en), .CARD_CLK_STOPPED(stopped),
    .CARD_CLK_SLOWED(slowed), .IRQ(irq));
  scpc_card_model card (.clk(clk), .rstn(rstn), .want_idle(want_idle), .poke(poke),
    .access(card_access), .idle(card_idle));

  always #2 clk = ~clk;

  function automatic logic [31:0] pm_exp(input logic [31:0] w);
    return w & 32'h0001_0001;
  endfunction

  task automatic conclude();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (k == 50) begin
      err_total++;
      conclude();
    end
  endtask

  task automatic wait_mode(input logic [1:0] want);
    int k;
    k = 0;
    @(negedge clk);
    while ({slowed, stopped} !== want && k < 60) begin
      @(negedge clk);
      k++;
    end
    chk(32'({slowed, stopped}), 32'(want));
    if ({slowed, stopped} !== want) conclude();
    @(posedge clk);
  endtask

  task automatic pulse();
    poke <= 1'b1;
    @(posedge clk);
    poke <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    {clk, rstn, psel, penable, pwrite, host, want_idle, poke} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    err_total = 0;
    checks = 0;
    void'($urandom(64));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h20, '0);
    chk(rd, 32'h0);
    chk(32'(perr), 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'hffff_ffff : $urandom;
      apb(1'b1, 8'h20, v);
      apb(1'b0, 8'h20, '0);
      chk(rd, pm_exp(v));
    end
    apb(1'b1, 8'h24, '1);
    chk(32'(perr), 32'h1);
    apb(1'b0, 8'h20, '0);
    chk(rd, pm_exp(v));
    apb(1'b1, 8'h34, 32'h7);
    pulse();
    chk(32'(irq), 32'h1);
    apb(1'b0, 8'h20, '0);
    chk(rd, pm_exp(v) | 32'h0200_0000);
    apb(1'b0, 8'h20, '0);
    chk(rd, pm_exp(v));
    apb(1'b1, 8'h38, 32'h7);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h34, 32'h0);
    pulse();
    chk(32'(irq), 32'h0);
    apb(1'b0, 8'h30, '0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h20, '0);
    // Stop mode, idle alone suffices
    apb(1'b1, 8'h10, 32'h80);
    apb(1'b1, 8'h20, 32'h0001_0000);
    want_idle <= 1'b1;
    wait_mode(2'b01);
    chk(32'(clk_en), 32'h0);
    apb(1'b0, 8'h20, '0);
    chk(rd, 32'h0101_0000);
    pulse();
    want_idle <= 1'b0;
    wait_mode(2'b00);
    apb(1'b0, 8'h20, '0);
    chk(rd, 32'h0201_0000);
    // Slow mode: two open cycles in any 32
    apb(1'b1, 8'h20, 32'h0001_0001);
    want_idle <= 1'b1;
    wait_mode(2'b10);
    n = 0;
    repeat (32) begin
      @(negedge clk);
      if (clk_en === 1'b1) n++;
    end
    chk(32'(n), 32'd2);
    @(posedge clk);
    apb(1'b1, 8'h20, 32'h1);
    wait_mode(2'b00);
    repeat (12) @(posedge clk);
    chk(32'({slowed, stopped}), 32'h0);
    // Host clock must slow too when the policy bit is clear
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h20, 32'h0001_0000);
    repeat (12) @(posedge clk);
    chk(32'({slowed, stopped}), 32'h0);
    host <= 1'b1;
    wait_mode(2'b01);
    conclude();
  end
endmodule

`default_nettype wire

/* design/scpc_pkg.sv */
// Constants, types and state layout for the socket clock power control block
package scpc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] SCPC_OFS_SKT_CTRL = 8'h10;
  localparam logic [7:0] SCPC_OFS_PM       = 8'h20;
  localparam logic [7:0] SCPC_OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] SCPC_OFS_IRQ_EN   = 8'h34;
  localparam logic [7:0] SCPC_OFS_IRQ_CLR  = 8'h38;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SCPC_PM_ACCESS_BIT   = 25;
  localparam int SCPC_PM_RATE_BIT     = 24;
  localparam int SCPC_PM_EN_BIT       = 16;
  localparam int SCPC_PM_SEL_BIT      = 0;
  localparam int SCPC_CTRL_POLICY_BIT = 7;
  localparam int SCPC_IRQ_ACCESS_BIT  = 0;
  localparam int SCPC_IRQ_RATE_BIT    = 1;
  localparam int SCPC_IRQ_RESTORE_BIT = 2;
  localparam int SCPC_IRQ_W           = 3;
  localparam int SCPC_LANE_SHIFT      = 3;

  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam logic [31:0] SCPC_PM_RESET   = 32'h0000_0000;
  localparam logic [31:0] SCPC_ZERO_WORD  = 32'h0000_0000;
  localparam logic [2:0]  SCPC_IRQ_RESET  = 3'h0;
  localparam int          SCPC_SLOW_DIV   = 16;
  localparam int          SCPC_DIV_W      = 4;
  localparam int          SCPC_ADDR_W     = 8;

  typedef logic [SCPC_DIV_W-1:0] scpc_div_t;
  typedef logic [SCPC_IRQ_W-1:0] scpc_irq_t;

  typedef enum logic [1:0] {
    SCPC_RUN  = 2'b00,
    SCPC_STOP = 2'b01,
    SCPC_SLOW = 2'b10
  } scpc_mode_e;

  typedef struct packed {
    scpc_mode_e  mode;
    scpc_div_t   div_cnt;
    logic        clk_en;
    logic        policy_en;
    logic        sel;
    logic        idle_policy;
    logic        access_seen;
    scpc_irq_t   irq_stat;
    scpc_irq_t   irq_en;
    logic [31:0] prdata;
    logic        pslverr;
  } scpc_state_s;

endpackage

/* design/scpc_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module scpc_sync #(
  parameter int W = 2
) (
  input  wire logic         CLK,
  input  wire logic         RSTN,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } scpc_sync_s;

  scpc_sync_s st;
  scpc_sync_s next_st;
  logic [W-1:0] agree;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // First stage feeds only the second, never the filter
  always_comb begin
    next_st    = st;
    next_st.s1 = D;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    agree      = ~(st.s2 ^ st.s3);
    next_st.q  = (st.s2 & agree) | (st.q & ~agree);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign Q = st.q;

endmodule

`default_nettype wire

/* design/scpc_top.sv */
// Socket clock power control: policy registers, idle clock gating, APB slave
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Gate or slow card clock only when idle
// - Card access sets access-seen bit 25
// - Reading the register clears access-seen
// - Bit 24 shows clock rate changed
// - Bit 16 enables policy, resets to zero
// - Select 0 lets idle clock stop
// - Select 1 slows clock by sixteen
// - Reserved bits always read zero
// - Register resets to all zeros
// - Idle policy bit clear needs host slowing
module scpc_top #(
  parameter int          ADDR_W   = scpc_pkg::SCPC_ADDR_W,
  parameter int unsigned SLOW_DIV = scpc_pkg::SCPC_SLOW_DIV
) (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              CARD_ACCESS,
  input  wire logic              CARD_IDLE,
  input  wire logic              HOST_CLK_SLOWING,
  output logic                   CARD_CLK_EN,
  output logic                   CARD_CLK_STOPPED,
  output logic                   CARD_CLK_SLOWED,
  output logic                   IRQ
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic addr_is(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        ofs
  );
    addr_is = (addr == ADDR_W'(ofs));
  endfunction

  // Byte lane strobe covering a given bit position
  function automatic logic lane_on(
    input logic [3:0] strb,
    input int         pos
  );
    lane_on = strb[2'(pos >> scpc_pkg::SCPC_LANE_SHIFT)];
  endfunction

  // Stop and slow both count as a changed clock rate
  function automatic logic is_gated(
    input scpc_pkg::scpc_mode_e mode
  );
    is_gated = (mode != scpc_pkg::SCPC_RUN);
  endfunction

  // Power-management word; every bit not named here reads zero
  function automatic logic [31:0] pm_word(
    input logic access,
    input logic rate,
    input logic en,
    input logic sel
  );
    pm_word                               = scpc_pkg::SCPC_ZERO_WORD;
    pm_word[scpc_pkg::SCPC_PM_ACCESS_BIT] = access;
    pm_word[scpc_pkg::SCPC_PM_RATE_BIT]   = rate;
    pm_word[scpc_pkg::SCPC_PM_EN_BIT]     = en;
    pm_word[scpc_pkg::SCPC_PM_SEL_BIT]    = sel;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  scpc_pkg::scpc_state_s st;
  scpc_pkg::scpc_state_s next_st;

  logic [1:0]              pin_raw;
  logic [1:0]              pin_sync;
  logic                    card_idle;
  logic                    host_slowing;
  logic                    setup;
  logic                    wr;
  logic                    rd;
  logic                    hit_pm;
  logic                    hit_ctrl;
  logic                    hit_stat;
  logic                    hit_en;
  logic                    hit_clr;
  logic                    idle_ok;
  logic                    rate_changed;
  logic                    rd_pm_clear;
  logic [31:0]             rdata;
  logic                    rerr;
  scpc_pkg::scpc_irq_t     irq_event;
  scpc_pkg::scpc_irq_t     irq_clear;
  scpc_pkg::scpc_irq_t     irq_keep;
  scpc_pkg::scpc_div_t     div_last;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Card access pulse is already on this clock; only the pins are filtered
  assign pin_raw = {HOST_CLK_SLOWING, CARD_IDLE};

  scpc_sync #(
    .W (2)
  ) u_pin_sync (
    .CLK  (CLK),
    .RSTN (RSTN),
    .D    (pin_raw),
    .Q    (pin_sync)
  );

  assign card_idle    = pin_sync[0];
  assign host_slowing = pin_sync[1];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Zero wait states: every access phase completes at once
  assign PREADY = 1'b1;
  assign setup  = PSEL & ~PENABLE;
  assign wr     = PSEL & PENABLE & PWRITE;
  assign rd     = PSEL & PENABLE & ~PWRITE;

  always_comb begin
    hit_pm   = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_en   = 1'b0;
    hit_clr  = 1'b0;
    if (addr_is(PADDR, scpc_pkg::SCPC_OFS_PM)) begin
      hit_pm = 1'b1;
    end else if (addr_is(PADDR, scpc_pkg::SCPC_OFS_SKT_CTRL)) begin
      hit_ctrl = 1'b1;
    end else if (addr_is(PADDR, scpc_pkg::SCPC_OFS_IRQ_STAT)) begin
      hit_stat = 1'b1;
    end else if (addr_is(PADDR, scpc_pkg::SCPC_OFS_IRQ_EN)) begin
      hit_en = 1'b1;
    end else if (addr_is(PADDR, scpc_pkg::SCPC_OFS_IRQ_CLR)) begin
      hit_clr = 1'b1;
    end
  end

  // ----------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------
  assign rate_changed = is_gated(st.mode);

  always_comb begin
    rdata = scpc_pkg::SCPC_ZERO_WORD;
    rerr  = 1'b0;
    if (hit_pm) begin
      rdata = pm_word(st.access_seen, rate_changed, st.policy_en, st.sel);
    end else if (hit_ctrl) begin
      rdata[scpc_pkg::SCPC_CTRL_POLICY_BIT] = st.idle_policy;
    end else if (hit_stat) begin
      rdata[scpc_pkg::SCPC_IRQ_W-1:0] = st.irq_stat;
    end else if (hit_en) begin
      rdata[scpc_pkg::SCPC_IRQ_W-1:0] = st.irq_en;
    end else if (hit_clr) begin
      rdata = scpc_pkg::SCPC_ZERO_WORD;
    end else begin
      rerr = 1'b1;
    end
  end

  // Only a flag that was actually returned is cleared, so an access
  // landing between setup and access phase is not lost.
  assign rd_pm_clear = rd & hit_pm
                     & st.prdata[scpc_pkg::SCPC_PM_ACCESS_BIT];

  // ----------------------------------------
  // Idle qualification
  // ----------------------------------------
  // A card access in flight always vetoes gating
  assign idle_ok = st.policy_en
                 & card_idle
                 & (st.idle_policy | host_slowing)
                 & ~CARD_ACCESS;

  // SLOW_DIV must fit the count width; a larger value would wrap
  assign div_last = scpc_pkg::scpc_div_t'(SLOW_DIV - 1);

  // ----------------------------------------
  // Interrupt events and clears
  // ----------------------------------------
  always_comb begin
    irq_event = scpc_pkg::SCPC_IRQ_RESET;
    irq_clear = scpc_pkg::SCPC_IRQ_RESET;
    irq_event[scpc_pkg::SCPC_IRQ_ACCESS_BIT] = CARD_ACCESS;
    irq_event[scpc_pkg::SCPC_IRQ_RATE_BIT] =
      ~is_gated(st.mode) & idle_ok;
    irq_event[scpc_pkg::SCPC_IRQ_RESTORE_BIT] =
      is_gated(st.mode) & ~idle_ok;
    if (wr && hit_clr && PSTRB[0]) begin
      irq_clear = PWDATA[scpc_pkg::SCPC_IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Sticky interrupt status, one cell per event
  // ----------------------------------------
  // Set wins over a clear in the same cycle
  for (genvar i = 0; i < scpc_pkg::SCPC_IRQ_W; i++) begin : g_sticky
    assign irq_keep[i] = irq_event[i] | (st.irq_stat[i] & ~irq_clear[i]);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;

    // Bus answer, loaded during setup, held through access
    if (setup) begin
      next_st.prdata  = rdata;
      next_st.pslverr = rerr;
    end

    // Set wins over a clearing read
    next_st.access_seen = CARD_ACCESS
                        | (st.access_seen & ~rd_pm_clear);

    // Writable fields only; status and reserved bits drop writes
    if (wr && hit_pm) begin
      if (lane_on(PSTRB, scpc_pkg::SCPC_PM_EN_BIT)) begin
        next_st.policy_en = PWDATA[scpc_pkg::SCPC_PM_EN_BIT];
      end
      if (lane_on(PSTRB, scpc_pkg::SCPC_PM_SEL_BIT)) begin
        next_st.sel = PWDATA[scpc_pkg::SCPC_PM_SEL_BIT];
      end
    end
    // Idle policy lives in the socket control word, bit 7 only
    if (wr && hit_ctrl) begin
      if (lane_on(PSTRB, scpc_pkg::SCPC_CTRL_POLICY_BIT)) begin
        next_st.idle_policy = PWDATA[scpc_pkg::SCPC_CTRL_POLICY_BIT];
      end
    end
    if (wr && hit_en && PSTRB[0]) begin
      next_st.irq_en = PWDATA[scpc_pkg::SCPC_IRQ_W-1:0];
    end

    // Sticky status from the per-event cells
    next_st.irq_stat = irq_keep;

    // Clock mode
    case (st.mode)
      scpc_pkg::SCPC_RUN: begin
        if (idle_ok) begin
          if (st.sel) begin
            next_st.mode = scpc_pkg::SCPC_SLOW;
          end else begin
            next_st.mode = scpc_pkg::SCPC_STOP;
          end
          next_st.div_cnt = '0;
        end
      end
      scpc_pkg::SCPC_STOP: begin
        if (!idle_ok) begin
          next_st.mode = scpc_pkg::SCPC_RUN;
        end else if (st.sel) begin
          next_st.mode    = scpc_pkg::SCPC_SLOW;
          next_st.div_cnt = '0;
        end
      end
      scpc_pkg::SCPC_SLOW: begin
        if (!idle_ok) begin
          next_st.mode = scpc_pkg::SCPC_RUN;
        end else if (!st.sel) begin
          next_st.mode = scpc_pkg::SCPC_STOP;
        end else if (st.div_cnt == div_last) begin
          next_st.div_cnt = '0;
        end else begin
          next_st.div_cnt = st.div_cnt + scpc_pkg::scpc_div_t'(1);
        end
      end
      default: begin
        next_st.mode = scpc_pkg::SCPC_RUN;
      end
    endcase

    // One enable in SLOW_DIV cycles when slowed, none when stopped
    case (next_st.mode)
      scpc_pkg::SCPC_RUN: begin
        next_st.clk_en = 1'b1;
      end
      scpc_pkg::SCPC_SLOW: begin
        next_st.clk_en = (next_st.div_cnt == '0);
      end
      default: begin
        next_st.clk_en = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      // Clock runs freely out of reset, with the policy disabled
      st.mode        <= scpc_pkg::SCPC_RUN;
      st.div_cnt     <= '0;
      st.clk_en      <= 1'b1;
      st.policy_en   <= scpc_pkg::SCPC_PM_RESET[scpc_pkg::SCPC_PM_EN_BIT];
      st.idle_policy <= 1'b0;
      st.prdata      <= scpc_pkg::SCPC_ZERO_WORD;
      st.pslverr     <= 1'b0;
      st.sel         <= scpc_pkg::SCPC_PM_RESET[scpc_pkg::SCPC_PM_SEL_BIT];
      st.access_seen <= scpc_pkg::SCPC_PM_RESET[scpc_pkg::SCPC_PM_ACCESS_BIT];
      st.irq_stat    <= scpc_pkg::SCPC_IRQ_RESET;
      st.irq_en      <= scpc_pkg::SCPC_IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA           = st.prdata;
  // Error shown only in the access phase, so an idle bus reads clean
  assign PSLVERR          = st.pslverr & PSEL & PENABLE;
  assign CARD_CLK_EN      = st.clk_en;
  assign CARD_CLK_STOPPED = (st.mode == scpc_pkg::SCPC_STOP);
  assign CARD_CLK_SLOWED  = (st.mode == scpc_pkg::SCPC_SLOW);
  assign IRQ              = |(st.irq_stat & st.irq_en);

endmodule

`default_nettype wire
